// file: rtl/rtcc_core.sv
// Time and calendar counters with oscillation adjustment, behind a simple
// register port. Assumes the serial front end turns bus transfers into
// single-cycle write strobes and sampled reads, and that the oscillator
// arrives as a synchronous tick. Power-up detection lives elsewhere.
module rtcc_core #(
  parameter logic [15:0] NOMINAL_CYCLES = rtcc_pkg::SECOND_NOMINAL_CYCLES // Cycles per second
) (
  input  wire logic       i_clk,       // System clock, 50 MHz
  input  wire logic       i_rst_n,     // Synchronous reset, active low
  input  wire logic       i_osc_tick,  // Oscillator cycle pulse
  input  wire logic       i_power_up,  // Power-up flag level
  input  wire logic       i_mode_12h,  // 12-hour mode select
  input  wire logic       i_wr_en,     // Register write strobe
  input  wire logic [3:0] i_addr,      // Register address
  input  wire logic [7:0] i_wr_data,   // Register write data
  output logic      [7:0] o_rd_data,   // Registered read data
  output logic            o_sec_pulse  // One-cycle pulse per second
);

  rtcc_pkg::rtcc_core_s cur;
  rtcc_pkg::rtcc_core_s nxt;

  logic        sec_tick;
  logic        sec_write;
  logic        trim_slot;
  logic [15:0] sec_length;

  // BCD increment of a two-digit value
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    logic [7:0] r;
    r = 8'h00;
    if (v[3:0] == 4'h9) begin
      r = {v[7:4] + 4'h1, 4'h0};
    end else begin
      r = {v[7:4], v[3:0] + 4'h1};
    end
    return r;
  endfunction

  // Leap year from a BCD year
  function automatic logic is_leap(input logic [7:0] y);
    logic r;
    r = 1'b0;
    if (y[4]) begin
      r = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
    end else begin
      r = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
    end
    return r;
  endfunction

  // Last day of a month, BCD
  function automatic logic [7:0] month_days(input logic [7:0] m, input logic [7:0] y);
    logic [7:0] r;
    r = rtcc_pkg::DAYS_LONG;
    if (m == rtcc_pkg::MONTH_FEB) begin
      r = is_leap(y) ? rtcc_pkg::DAYS_FEB_LEAP : rtcc_pkg::DAYS_FEB;
    end else if ((m == rtcc_pkg::MONTH_APR) || (m == rtcc_pkg::MONTH_JUN) ||
                 (m == rtcc_pkg::MONTH_SEP) || (m == rtcc_pkg::MONTH_NOV)) begin
      r = rtcc_pkg::DAYS_SHORT;
    end
    return r;
  endfunction

  // Hour wraps into the next day
  function automatic logic hour_wraps(input logic [7:0] h, input logic mode_12h);
    logic r;
    r = 1'b0;
    if (mode_12h) begin
      r = h[rtcc_pkg::HOUR_PM_BIT] && (h[4:0] == rtcc_pkg::HOUR12_ELEVEN);
    end else begin
      r = (h == rtcc_pkg::HOUR24_LAST);
    end
    return r;
  endfunction

  // Next hour value
  function automatic logic [7:0] hour_next(input logic [7:0] h, input logic mode_12h);
    logic [7:0] r;
    logic [7:0] inc;
    logic       pm;
    pm  = h[rtcc_pkg::HOUR_PM_BIT];
    inc = bcd_inc({3'b000, h[4:0]});
    r   = 8'h00;
    if (mode_12h) begin
      // afternoon bit and 12 o'clock codes
      if (h[4:0] == rtcc_pkg::HOUR12_TWELVE) begin
        r = {2'b00, pm, rtcc_pkg::HOUR12_ONE};
      end else if (h[4:0] == rtcc_pkg::HOUR12_ELEVEN) begin
        r = {2'b00, ~pm, rtcc_pkg::HOUR12_TWELVE};
      end else begin
        r = {2'b00, pm, inc[4:0]};
      end
    end else if (h == rtcc_pkg::HOUR24_LAST) begin
      r = 8'h00;
    end else begin
      r = bcd_inc(h);
    end
    return r;
  endfunction

  // Oscillator cycles in the current second
  function automatic logic [15:0] trim_length(input logic [15:0] nominal,
                                              input logic [7:0]  trim,
                                              input logic        apply);
    logic [15:0] r;
    logic [15:0] add_cycles;
    logic [15:0] sub_cycles;
    add_cycles = {9'h000, trim[5:0], 1'b0} - 16'h0002;
    sub_cycles = {9'h000, ~trim[5:0], 1'b0} + 16'h0002;
    r = nominal;
    // amount bits five to one zero
    if (!apply || (trim[5:1] == 5'h00)) begin
      r = nominal;
    end else if (trim[rtcc_pkg::TRIM_DIRECTION_BIT]) begin
      r = nominal - sub_cycles;
    end else begin
      r = nominal + add_cycles;
    end
    return r;
  endfunction

  // Register readback, unused bits zero
  function automatic logic [7:0] read_mux(input rtcc_pkg::rtcc_core_s s, input logic [3:0] a);
    logic [7:0] r;
    r = 8'h00;
    case (a)
      rtcc_pkg::ADDR_SECONDS_COUNT:      r = s.seconds & rtcc_pkg::SECONDS_MASK;
      rtcc_pkg::ADDR_MINUTES_COUNT:      r = s.minutes & rtcc_pkg::MINUTES_MASK;
      rtcc_pkg::ADDR_HOURS_COUNT:        r = s.hours & rtcc_pkg::HOURS_MASK;
      rtcc_pkg::ADDR_WEEKDAY_COUNT:      r = {5'h00, s.weekday};
      rtcc_pkg::ADDR_DAY_OF_MONTH_COUNT: r = s.mday & rtcc_pkg::DAY_OF_MONTH_MASK;
      rtcc_pkg::ADDR_MONTH_COUNT:        r = s.month & rtcc_pkg::MONTH_MASK;
      rtcc_pkg::ADDR_YEAR_COUNT:         r = s.year & rtcc_pkg::YEAR_MASK;
      rtcc_pkg::ADDR_RATE_TRIM:          r = s.trim & rtcc_pkg::RATE_TRIM_MASK;
      default:                           r = 8'h00;
    endcase
    return r;
  endfunction

  assign sec_write = i_wr_en && (i_addr == rtcc_pkg::ADDR_SECONDS_COUNT);

  assign trim_slot = (cur.seconds == rtcc_pkg::TRIM_SLOT_0) ||
                     (!cur.trim[rtcc_pkg::TRIM_INTERVAL_SELECT_BIT] &&
                      ((cur.seconds == rtcc_pkg::TRIM_SLOT_20) ||
                       (cur.seconds == rtcc_pkg::TRIM_SLOT_40)));

  assign sec_length = trim_length(NOMINAL_CYCLES, cur.trim, trim_slot && !cur.trim_skip);

  rtcc_divider u_divider (
    .i_clk      (i_clk),
    .i_rst_n    (i_rst_n),
    .i_osc_tick (i_osc_tick),
    .i_clear    (sec_write),
    .i_length   (sec_length),
    .o_sec_tick (sec_tick)
  );

  always_comb begin
    logic c_sec;
    logic c_min;
    logic c_hour;
    logic c_day;
    logic c_month;
    c_sec   = 1'b0;
    c_min   = 1'b0;
    c_hour  = 1'b0;
    c_day   = 1'b0;
    c_month = 1'b0;
    nxt           = cur;
    nxt.sec_pulse = sec_tick;
    nxt.rd_data   = read_mux(cur, i_addr);

    if (sec_tick) begin
      c_sec       = (cur.seconds == rtcc_pkg::MINSEC_LAST);
      nxt.seconds = c_sec ? 8'h00 : bcd_inc(cur.seconds);
      // a new slot may adjust again
      nxt.trim_skip = 1'b0;
    end
    if (c_sec) begin
      c_min       = (cur.minutes == rtcc_pkg::MINSEC_LAST);
      nxt.minutes = c_min ? 8'h00 : bcd_inc(cur.minutes);
    end
    if (c_min) begin
      c_hour    = hour_wraps(cur.hours, i_mode_12h);
      nxt.hours = hour_next(cur.hours, i_mode_12h);
    end
    if (c_hour) begin
      if (cur.weekday == rtcc_pkg::WEEKDAY_LAST) begin
        nxt.weekday = 3'h0;
      end else begin
        nxt.weekday = cur.weekday + 3'h1;
      end
      c_day    = (cur.mday == month_days(cur.month, cur.year));
      nxt.mday = c_day ? rtcc_pkg::DAY_FIRST : bcd_inc(cur.mday);
    end
    if (c_day) begin
      c_month   = (cur.month == rtcc_pkg::MONTH_LAST);
      nxt.month = c_month ? 8'h01 : bcd_inc(cur.month);
    end
    if (c_month) begin
      nxt.year = (cur.year == rtcc_pkg::YEAR_LAST) ? 8'h00 : bcd_inc(cur.year);
    end

    // Host writes win over counting for the addressed register
    if (i_wr_en) begin
      case (i_addr)
        rtcc_pkg::ADDR_SECONDS_COUNT:      nxt.seconds = i_wr_data & rtcc_pkg::SECONDS_MASK;
        rtcc_pkg::ADDR_MINUTES_COUNT:      nxt.minutes = i_wr_data & rtcc_pkg::MINUTES_MASK;
        rtcc_pkg::ADDR_HOURS_COUNT:        nxt.hours = i_wr_data & rtcc_pkg::HOURS_MASK;
        rtcc_pkg::ADDR_WEEKDAY_COUNT:      nxt.weekday = i_wr_data[2:0];
        rtcc_pkg::ADDR_DAY_OF_MONTH_COUNT: nxt.mday = i_wr_data & rtcc_pkg::DAY_OF_MONTH_MASK;
        rtcc_pkg::ADDR_MONTH_COUNT:        nxt.month = i_wr_data & rtcc_pkg::MONTH_MASK;
        rtcc_pkg::ADDR_YEAR_COUNT:         nxt.year = i_wr_data & rtcc_pkg::YEAR_MASK;
        rtcc_pkg::ADDR_RATE_TRIM: begin
          nxt.trim = i_wr_data & rtcc_pkg::RATE_TRIM_MASK;
          nxt.trim_skip = 1'b1;
        end
        default: begin
          nxt.trim_skip = nxt.trim_skip;
        end
      endcase
    end

    if (i_power_up) begin
      nxt.trim = rtcc_pkg::RATE_TRIM_RESET;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cur           <= '0;
      cur.seconds   <= rtcc_pkg::SECONDS_RESET;
      cur.minutes   <= rtcc_pkg::MINUTES_RESET;
      cur.hours     <= rtcc_pkg::HOURS_RESET;
      cur.weekday   <= rtcc_pkg::WEEKDAY_RESET;
      cur.mday      <= rtcc_pkg::DAY_OF_MONTH_RESET;
      cur.month     <= rtcc_pkg::MONTH_RESET;
      cur.year      <= rtcc_pkg::YEAR_RESET;
      cur.trim      <= rtcc_pkg::RATE_TRIM_RESET;
    end else begin
      cur <= nxt;
    end
  end

  assign o_rd_data   = cur.rd_data;
  assign o_sec_pulse = cur.sec_pulse;

endmodule

// file: pkg/rtcc_pkg.sv
// Constants, field positions and state types for the timekeeping core.
// Assumes the register port carries 4-bit addresses and 8-bit data.
package rtcc_pkg;

  // Register addresses
  localparam logic [3:0] ADDR_SECONDS_COUNT      = 4'h0;
  localparam logic [3:0] ADDR_MINUTES_COUNT      = 4'h1;
  localparam logic [3:0] ADDR_HOURS_COUNT        = 4'h2;
  localparam logic [3:0] ADDR_WEEKDAY_COUNT      = 4'h3;
  localparam logic [3:0] ADDR_DAY_OF_MONTH_COUNT = 4'h4;
  localparam logic [3:0] ADDR_MONTH_COUNT        = 4'h5;
  localparam logic [3:0] ADDR_YEAR_COUNT         = 4'h6;
  localparam logic [3:0] ADDR_RATE_TRIM          = 4'h7;

  // Implemented bits of each register
  localparam logic [7:0] SECONDS_MASK      = 8'h7f;
  localparam logic [7:0] MINUTES_MASK      = 8'h7f;
  localparam logic [7:0] HOURS_MASK        = 8'h3f;
  localparam logic [7:0] WEEKDAY_MASK      = 8'h07;
  localparam logic [7:0] DAY_OF_MONTH_MASK = 8'h3f;
  localparam logic [7:0] MONTH_MASK        = 8'h1f;
  localparam logic [7:0] YEAR_MASK         = 8'hff;
  localparam logic [7:0] RATE_TRIM_MASK    = 8'hff;

  // Field positions
  localparam int TRIM_INTERVAL_SELECT_BIT = 7;
  localparam int TRIM_DIRECTION_BIT       = 6;
  localparam int HOUR_PM_BIT              = 5;

  // Reset values
  localparam logic [7:0] SECONDS_RESET      = 8'h00;
  localparam logic [7:0] MINUTES_RESET      = 8'h00;
  localparam logic [7:0] HOURS_RESET        = 8'h12;
  localparam logic [2:0] WEEKDAY_RESET      = 3'h0;
  localparam logic [7:0] DAY_OF_MONTH_RESET = 8'h01;
  localparam logic [7:0] MONTH_RESET        = 8'h01;
  localparam logic [7:0] YEAR_RESET         = 8'h00;
  localparam logic [7:0] RATE_TRIM_RESET    = 8'h00;

  // Counter limits, all BCD
  localparam logic [7:0] MINSEC_LAST    = 8'h59;
  localparam logic [7:0] HOUR24_LAST    = 8'h23;
  localparam logic [4:0] HOUR12_ELEVEN  = 5'h11;
  localparam logic [4:0] HOUR12_TWELVE  = 5'h12;
  localparam logic [4:0] HOUR12_ONE     = 5'h01;
  localparam logic [2:0] WEEKDAY_LAST   = 3'h6;
  localparam logic [7:0] DAY_FIRST      = 8'h01;
  localparam logic [7:0] MONTH_LAST     = 8'h12;
  localparam logic [7:0] YEAR_LAST      = 8'h99;
  localparam logic [7:0] DAYS_LONG      = 8'h31;
  localparam logic [7:0] DAYS_SHORT     = 8'h30;
  localparam logic [7:0] DAYS_FEB_LEAP  = 8'h29;
  localparam logic [7:0] DAYS_FEB       = 8'h28;
  localparam logic [7:0] MONTH_FEB      = 8'h02;
  localparam logic [7:0] MONTH_APR      = 8'h04;
  localparam logic [7:0] MONTH_JUN      = 8'h06;
  localparam logic [7:0] MONTH_SEP      = 8'h09;
  localparam logic [7:0] MONTH_NOV      = 8'h11;

  // Adjustment slots
  localparam logic [7:0] TRIM_SLOT_0    = 8'h00;
  localparam logic [7:0] TRIM_SLOT_20   = 8'h20;
  localparam logic [7:0] TRIM_SLOT_40   = 8'h40;

  // Oscillator cycles in one unadjusted second
  localparam logic [15:0] SECOND_NOMINAL_CYCLES = 16'h8000;

  typedef struct packed {
    logic [15:0] count;
    logic        sec_tick;
  } rtcc_div_s;

  typedef struct packed {
    logic [7:0] seconds;
    logic [7:0] minutes;
    logic [7:0] hours;
    logic [2:0] weekday;
    logic [7:0] mday;
    logic [7:0] month;
    logic [7:0] year;
    logic [7:0] trim;
    logic       trim_skip;
    logic [7:0] rd_data;
    logic       sec_pulse;
  } rtcc_core_s;

endpackage

// file: rtl/rtcc_divider.sv
// Sub-second divider: counts oscillator ticks into one-second ticks.
// Assumes i_osc_tick is a one-cycle pulse per oscillator cycle, synchronous to i_clk.
module rtcc_divider (
  input  wire logic        i_clk,      // System clock
  input  wire logic        i_rst_n,    // Synchronous reset, active low
  input  wire logic        i_osc_tick, // One oscillator cycle elapsed
  input  wire logic        i_clear,    // Restart the current second
  input  wire logic [15:0] i_length,   // Oscillator cycles in this second
  output logic             o_sec_tick  // One-cycle pulse at end of second
);

  rtcc_pkg::rtcc_div_s cur;
  rtcc_pkg::rtcc_div_s nxt;

  always_comb begin
    nxt          = cur;
    nxt.sec_tick = 1'b0;
    if (i_clear) begin
      nxt.count = 16'h0000;
    end else if (i_osc_tick) begin
      if (cur.count >= i_length - 16'h0001) begin
        nxt.count    = 16'h0000;
        nxt.sec_tick = 1'b1;
      end else begin
        nxt.count = cur.count + 16'h0001;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cur <= '0;
    end else begin
      cur <= nxt;
    end
  end

  assign o_sec_tick = cur.sec_tick;

endmodule

// file: testbench/rtcc_host.sv
// Host processor model on the register port of the timekeeping core.
// Assumes a free-running clock; changes its outputs after falling edges.
module rtcc_host (
  input  wire logic       i_clk,     // System clock
  input  wire logic [7:0] i_rd_data, // Read data from the core
  output logic            o_wr_en,   // Write strobe
  output logic      [3:0] o_addr,    // Register address
  output logic      [7:0] o_wr_data  // Write data
);
  initial begin
    o_wr_en = 1'b0;
    o_addr = 4'h0;
    o_wr_data = 8'h00;
  end

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge i_clk);
    o_wr_en = 1'b1;
    o_addr = a;
    o_wr_data = d;
    @(negedge i_clk);
    o_wr_en = 1'b0;
    o_wr_data = ~d;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(negedge i_clk);
    o_addr = a;
    @(negedge i_clk);
    d = i_rd_data;
  endtask
endmodule

// file: testbench/rtcc_core_chk.sv
// Port assertions for the timekeeping core.
// Sees only the core's ports; attached by the bind below.
module rtcc_core_chk #(
  parameter logic [15:0] NOMINAL_CYCLES = rtcc_pkg::SECOND_NOMINAL_CYCLES // Cycles per second
) (
  input wire logic       i_clk,       // System clock
  input wire logic       i_rst_n,     // Reset, active low
  input wire logic       i_osc_tick,  // Oscillator tick
  input wire logic       i_power_up,  // Power-up flag
  input wire logic       i_wr_en,     // Write strobe
  input wire logic [3:0] i_addr,      // Address
  input wire logic [7:0] o_rd_data,   // Read data
  input wire logic       o_sec_pulse  // Second pulse
);
  localparam int LEN_MIN = int'(NOMINAL_CYCLES) - 132;
  localparam int LEN_MAX = int'(NOMINAL_CYCLES) + 130;
  logic [15:0] tick_cnt;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  sequence s_sec_wr;
    i_wr_en && i_addr == rtcc_pkg::ADDR_SECONDS_COUNT;
  endsequence

  // Ticks since the current second began
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || o_sec_pulse || (i_wr_en && i_addr == rtcc_pkg::ADDR_SECONDS_COUNT)) begin
      tick_cnt <= 16'h0000;
    end else if (i_osc_tick) begin
      tick_cnt <= tick_cnt + 16'h0001;
    end
  end

  reset_quiet_a: assert property (disable iff (1'b0) !i_rst_n |=> o_rd_data == 8'h00 && !o_sec_pulse)
    else $error("outputs active after reset");
  pulse_single_a: assert property (o_sec_pulse |=> !o_sec_pulse)
    else $error("second pulse longer than one cycle");
  sec_clear_a: assert property (s_sec_wr |-> ##2 !o_sec_pulse [*8])
    else $error("second ended right after seconds write");
  len_short_a: assert property (o_sec_pulse && tick_cnt > 16'h0003 |-> tick_cnt >= LEN_MIN)
    else $error("second too short");
  len_long_a: assert property (tick_cnt <= LEN_MAX)
    else $error("second too long");
  unmapped_zero_a: assert property (i_addr[3] |=> o_rd_data == 8'h00)
    else $error("unmapped address reads nonzero");
  sec_bits_a: assert property (i_addr == 4'h0 |=> o_rd_data[7] == 1'b0)
    else $error("seconds bit 7 set");
  hour_bits_a: assert property (i_addr == 4'h2 |=> o_rd_data[7:6] == 2'b00)
    else $error("hour upper bits set");
  wday_range_a: assert property (i_addr == 4'h3 |=> o_rd_data[7:3] == 5'h00 && o_rd_data[2:0] != 3'h7)
    else $error("weekday out of range");
  month_range_a: assert property (i_addr == 4'h5 |=> o_rd_data inside {[8'h01:8'h09], [8'h10:8'h12]})
    else $error("month out of range");
  trim_held_a: assert property (i_power_up ##1 i_addr == 4'h7 |=> o_rd_data == 8'h00)
    else $error("trim not held clear");
endmodule

bind rtcc_core rtcc_core_chk #(.NOMINAL_CYCLES(NOMINAL_CYCLES)) i_rtcc_core_chk (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_osc_tick(i_osc_tick), .i_power_up(i_power_up),
  .i_wr_en(i_wr_en), .i_addr(i_addr), .o_rd_data(o_rd_data), .o_sec_pulse(o_sec_pulse));

// file: testbench/rtcc_core_test.sv
// Self-checking bench for the timekeeping core.
// Host model drives the register port; the oscillator ticks every clock except during the 52-clock stall.
module rtcc_core_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] N = 16'h00c8;
  // Mode, written counters, expected counters one second later
  localparam logic [112:0] ROWS [11] = '{
    {1'b0, 56'h59_59_23_06_31_12_99, 56'h00_00_00_00_01_01_00},
    {1'b0, 56'h59_59_23_02_30_04_05, 56'h00_00_00_03_01_05_05},
    {1'b0, 56'h59_59_23_03_28_02_01, 56'h00_00_00_04_01_03_01},
    {1'b0, 56'h59_59_23_04_28_02_04, 56'h00_00_00_05_29_02_04},
    {1'b0, 56'h59_59_23_05_29_02_00, 56'h00_00_00_06_01_03_00},
    {1'b0, 56'h59_59_23_01_31_01_19, 56'h00_00_00_02_01_02_19},
    {1'b0, 56'h59_59_09_01_15_06_10, 56'h00_00_10_01_15_06_10},
    {1'b0, 56'h59_09_00_00_10_08_90, 56'h00_10_00_00_10_08_90},
    {1'b1, 56'h59_59_31_06_30_09_21, 56'h00_00_12_00_01_10_21},
    {1'b1, 56'h59_59_11_02_10_07_22, 56'h00_00_32_02_10_07_22},
    {1'b1, 56'h59_59_12_02_10_07_22, 56'h00_00_01_02_10_07_22}};
  // Trim, start second, trim written late, change in length
  localparam logic [27:0] TR [12] = '{28'h07_00_0_0c, 28'h07_20_0_0c, 28'h07_40_0_0c,
    28'h87_20_0_00, 28'h87_00_0_0c, 28'h7e_40_0_fc, 28'h42_00_0_84, 28'h3f_00_0_7c,
    28'h01_00_0_00, 28'hc1_00_0_00, 28'h07_10_0_00, 28'h07_00_1_00};
  // Address, written value, value read back
  localparam logic [19:0] UB [6] = '{20'h0_a5_25, 20'h1_b2_32, 20'h2_c5_05, 20'h3_f3_03,
    20'h4_d5_15, 20'h9_55_00};
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       osc_tick = 1'b1;
  logic       power_up = 1'b0;
  logic       mode_12h = 1'b0;
  logic       wr_en;
  logic [3:0] addr;
  logic [7:0] wr_data;
  logic [7:0] rd_data;
  logic [7:0] v;
  logic       sec_pulse;
  int         bad_count = 0;
  int         total_checks = 0;
  int         cyc = 0;
  int         base;
  int         n;

  always #10 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  rtcc_core #(.NOMINAL_CYCLES(N)) i_rtcc_core (.i_clk(clk), .i_rst_n(rst_n),
    .i_osc_tick(osc_tick), .i_power_up(power_up), .i_mode_12h(mode_12h), .i_wr_en(wr_en),
    .i_addr(addr), .i_wr_data(wr_data), .o_rd_data(rd_data), .o_sec_pulse(sec_pulse));
  rtcc_host i_rtcc_host (.i_clk(clk), .i_rd_data(rd_data), .o_wr_en(wr_en), .o_addr(addr),
    .o_wr_data(wr_data));

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t read %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chkn(input int got, input int exp);
    total_checks++;
    if (got != exp) begin
      bad_count++;
      $display("BAD %0t second of %0d cycles, expected %0d", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    if (bad_count == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic wait_pulse();
    int k;
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (sec_pulse !== 1'b1 && k < 1000);
    chk8({7'h00, sec_pulse}, 8'h01);
  endtask

  task automatic meas(input logic [7:0] t, input logic [7:0] s, input logic late, output int c);
    int t0;
    if (!late) begin
      i_rtcc_host.wr(rtcc_pkg::ADDR_RATE_TRIM, t);
      wait_pulse();
    end
    i_rtcc_host.wr(rtcc_pkg::ADDR_SECONDS_COUNT, s);
    t0 = cyc;
    if (late) i_rtcc_host.wr(rtcc_pkg::ADDR_RATE_TRIM, t);
    wait_pulse();
    c = cyc - t0;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    stop_test();
  end

  initial begin
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    for (int a = 0; a < 8; a++) begin
      i_rtcc_host.rd(4'(a), v);
      chk8(v, 8'(64'h00_00_12_00_01_01_00_00 >> (56 - 8 * a)));
    end
    for (int r = 0; r < 11; r++) begin
      mode_12h = ROWS[r][112];
      for (int a = 6; a >= 0; a--) i_rtcc_host.wr(4'(a), ROWS[r][111 - 8 * a -: 8]);
      wait_pulse();
      for (int a = 0; a < 7; a++) begin
        i_rtcc_host.rd(4'(a), v);
        chk8(v, ROWS[r][55 - 8 * a -: 8]);
      end
    end
    meas(8'h00, 8'h20, 1'b0, base);
    // Pulse follows the last tick by one clock
    chkn(base, int'(N) + 1);
    for (int r = 0; r < 12; r++) begin
      meas(TR[r][27:20], TR[r][19:12], TR[r][8], n);
      chkn(n, base + $signed(TR[r][7:0]));
    end
    for (int r = 0; r < 6; r++) begin
      i_rtcc_host.wr(UB[r][19:16], UB[r][15:8]);
      i_rtcc_host.rd(UB[r][19:16], v);
      chk8(v, UB[r][7:0]);
    end
    i_rtcc_host.wr(rtcc_pkg::ADDR_RATE_TRIM, 8'h55);
    power_up = 1'b1;
    i_rtcc_host.wr(rtcc_pkg::ADDR_RATE_TRIM, 8'h33);
    i_rtcc_host.rd(rtcc_pkg::ADDR_RATE_TRIM, v);
    chk8(v, 8'h00);
    power_up = 1'b0;
    // Oscillator stalled for 52 clocks, 50 of them after the seconds write, stretches the second
    osc_tick = 1'b0;
    i_rtcc_host.wr(rtcc_pkg::ADDR_SECONDS_COUNT, 8'h20);
    n = cyc;
    repeat (50) @(negedge clk);
    osc_tick = 1'b1;
    wait_pulse();
    chkn(cyc - n, base + 50);
    stop_test();
  end
endmodule
